// ---- osccr_pkg.sv ----
/*
 * package for the oscillator select and reference clock output block:
 * register offsets, field positions, reset values and mode encodings.
 * assumes an APB slave with 32-bit data, one register per aligned word.
 */
package osccr_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [11:0] OSC_CTRL_ADDR    = 12'h000;
    localparam logic [11:0] REFCLK_CTRL_ADDR = 12'h004;
    localparam logic [11:0] CFG_ADDR         = 12'h008;
    localparam logic [11:0] STATUS_ADDR      = 12'h00C;

    // ************************************************************
    // oscillator control fields
    // ************************************************************
    localparam int          OSC_PLL_BIT    = 7;
    localparam int          OSC_FREQ_LSB   = 3;
    localparam int          OSC_SCS_LSB    = 0;
    localparam logic [7:0]  OSC_CTRL_RESET = 8'h38;
    localparam logic [7:0]  OSC_CTRL_MASK  = 8'hFB;

    // ************************************************************
    // reference clock control fields
    // ************************************************************
    localparam int          REF_EN_BIT       = 7;
    localparam int          REF_OE_BIT       = 6;
    localparam int          REF_SLEW_BIT     = 5;
    localparam int          REF_DUTY_LSB     = 3;
    localparam int          REF_DIV_LSB      = 0;
    localparam logic [7:0]  REF_CTRL_RESET   = 8'h00;

    // ************************************************************
    // configuration word copy (software visible, bench set)
    // ************************************************************
    localparam int          CFG_PLL_FORCE_BIT = 0;
    localparam int          CFG_INSTR_CLOCK_PIN_OUTPUT_BIT    = 1;
    localparam int          CFG_FOSC_LSB      = 2;
    localparam logic [7:0]  CFG_RESET         = 8'h00;

    // ************************************************************
    // oscillator source and mode encodings
    // ************************************************************
    typedef enum logic [1:0] {
        OSCCR_SRC_CFG,
        OSCCR_SRC_HF,
        OSCCR_SRC_MF,
        OSCCR_SRC_LF
    } osccr_src_t;

    localparam logic [2:0] FOSC_LP = 3'h0;
    localparam logic [2:0] FOSC_XT = 3'h1;
    localparam logic [2:0] FOSC_HS = 3'h2;

    localparam logic [3:0] FREQ_HF_MIN = 4'h8;
    localparam logic [3:0] FREQ_MF_MIN = 4'h2;
    localparam logic [3:0] FREQ_HF_TOP = 4'hF;
    localparam logic [3:0] FREQ_MF_TOP = 4'h7;

endpackage

// ---- osccr_osc_sel.sv ----
/*
 * oscillator selection decode: pll enable, source class and the
 * divide exponent of the chosen internal oscillator.
 * assumes the configuration word inputs are static between resets.
 */
`timescale 1ns/10ps
module osccr_osc_sel (
    // register fields
    input  wire logic                 sw_pll_enable,
    input  wire logic [3:0]           int_osc_freq_sel,
    input  wire logic [1:0]           sys_clk_select,
    // configuration word
    input  wire logic                 cfg_pll_force,
    // decoded selection
    output logic                      pll_on,
    output osccr_pkg::osccr_src_t     osc_src,
    output logic [2:0]                osc_div_exp
);

    // ************************************************************
    // pll control
    // ************************************************************
    assign pll_on = cfg_pll_force | sw_pll_enable;

    // ************************************************************
    // source and divide exponent
    // ************************************************************
    always_comb begin
        osc_div_exp = 3'h0;
        if (!sys_clk_select[1]) begin
            osc_src = osccr_pkg::OSCCR_SRC_CFG;
        end else if (int_osc_freq_sel >= osccr_pkg::FREQ_HF_MIN) begin
            osc_src     = osccr_pkg::OSCCR_SRC_HF;
            osc_div_exp = 3'(osccr_pkg::FREQ_HF_TOP - int_osc_freq_sel);
        end else if (int_osc_freq_sel > osccr_pkg::FREQ_MF_MIN) begin
            osc_src     = osccr_pkg::OSCCR_SRC_MF;
            osc_div_exp = 3'(osccr_pkg::FREQ_MF_TOP - int_osc_freq_sel);
        end else if (int_osc_freq_sel == osccr_pkg::FREQ_MF_MIN) begin
            // lowest mf code repeats the rate of the code above it
            osc_src     = osccr_pkg::OSCCR_SRC_MF;
            osc_div_exp = 3'(osccr_pkg::FREQ_MF_TOP - osccr_pkg::FREQ_MF_MIN - 4'h1);
        end else begin
            osc_src = osccr_pkg::OSCCR_SRC_LF;
        end
    end

endmodule

// ---- osccr_refclk_gen.sv ----
/*
 * reference clock generator: power-of-two divider of the system clock
 * with selectable duty cycle, settings loaded at period boundaries.
 * assumes pclk is the system clock and stops during sleep.
 */
`timescale 1ns/10ps
module osccr_refclk_gen #(
    parameter int DIV_W = 3
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // control
    input  wire logic             enable,
    input  wire logic [DIV_W-1:0] div_sel,
    input  wire logic [1:0]       duty_sel,
    // output
    output logic                  ref_clk
);

    localparam int CNT_W = (1 << DIV_W) - 1;

    logic [DIV_W-1:0] div_q;
    logic [1:0]       duty_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] last;
    logic [CNT_W-1:0] hi_len;
    logic             wrap;
    logic             level_d;
    logic             level_q;
    logic             neg_q;

    // ************************************************************
    // period counter, settings latched at the wrap
    // ************************************************************
    assign last = CNT_W'((64'd1 << div_q) - 64'd1);
    assign wrap = (cnt_q == last);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= '0;
            div_q  <= '0;
            duty_q <= 2'h0;
        end else if (!enable) begin
            cnt_q  <= '0;
            div_q  <= div_sel;
            duty_q <= duty_sel;
        end else if (wrap) begin
            cnt_q  <= '0;
            div_q  <= div_sel;
            duty_q <= duty_sel;
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    // ************************************************************
    // duty shaping
    // ************************************************************
    always_comb begin
        hi_len = '0;
        unique case (duty_q)
            2'h0: hi_len = '0;
            2'h1: hi_len = CNT_W'(last >> 2) + CNT_W'(1);
            2'h2: hi_len = CNT_W'(last >> 1) + CNT_W'(1);
            // at divide by two the extra quarter comes from the falling edge
            2'h3: hi_len = (div_q == DIV_W'(1)) ? CNT_W'(1) :
                           CNT_W'(last >> 1) + CNT_W'(last >> 2) + CNT_W'(2);
        endcase
        level_d = (cnt_q < hi_len);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= 1'b0;
        end else begin
            level_q <= enable & level_d;
        end
    end

    // half-cycle helper for divide by two: uses the falling edge
    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            neg_q <= 1'b0;
        end else begin
            neg_q <= level_q;
        end
    end

    // ************************************************************
    // output select
    // ************************************************************
    always_comb begin
        ref_clk = level_q;
        if (!enable || duty_q == 2'h0) begin
            ref_clk = 1'b0;
        end else if (div_q == '0) begin
            ref_clk = pclk;
        end else if (div_q == DIV_W'(1) && duty_q == 2'h1) begin
            ref_clk = level_q & ~neg_q & pclk;
        end else if (div_q == DIV_W'(1) && duty_q == 2'h3) begin
            ref_clk = level_q | (neg_q & pclk);
        end
    end

endmodule

// ---- osccr_top.sv ----
/*
 * oscillator control and reference clock output block with apb access.
 * assumes pclk is the system clock, presetn carries every device reset,
 * and the configuration word bits are held steady by the surroundings.
 */
`timescale 1ns/10ps
module osccr_top (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // configuration word
    input  wire logic        cfg_pll_force,
    input  wire logic        cfg_instr_clock_out_en,
    input  wire logic [2:0]  cfg_fosc,
    // clocking outputs
    output logic             pll_on,
    output logic [1:0]       osc_src,
    output logic [2:0]       osc_div_exp,
    // pin and internal clock
    output logic             refclk_pin_o,
    output logic             refclk_pin_oe,
    output logic             refclk_slew_limit_o,
    output logic             osc_second_pin_is_input,
    output logic             modulator_clk
);

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] osc_ctrl_q;
    logic [7:0] ref_ctrl_q;
    logic       instr_div_q;
    logic [1:0] instr_cnt_q;
    logic       ref_clk;
    logic       xtal_mode;
    logic       wr_en;
    logic       addr_ok;
    logic [31:0] prdata_d;
    logic [31:0] prdata_q;
    osccr_pkg::osccr_src_t src;

    assign pready  = 1'b1;
    assign addr_ok = (paddr == osccr_pkg::OSC_CTRL_ADDR) ||
                     (paddr == osccr_pkg::REFCLK_CTRL_ADDR) ||
                     (paddr == osccr_pkg::CFG_ADDR) ||
                     (paddr == osccr_pkg::STATUS_ADDR);
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_en   = psel & penable & pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_ctrl_q <= osccr_pkg::OSC_CTRL_RESET;
        end else if (wr_en && paddr == osccr_pkg::OSC_CTRL_ADDR) begin
            osc_ctrl_q <= pwdata[7:0] & osccr_pkg::OSC_CTRL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_ctrl_q <= osccr_pkg::REF_CTRL_RESET;
        end else if (wr_en && paddr == osccr_pkg::REFCLK_CTRL_ADDR) begin
            ref_ctrl_q <= pwdata[7:0];
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    always_comb begin
        prdata_d = 32'h0000_0000;
        unique case (paddr)
            osccr_pkg::OSC_CTRL_ADDR:    prdata_d[7:0] = osc_ctrl_q;
            osccr_pkg::REFCLK_CTRL_ADDR: prdata_d[7:0] = ref_ctrl_q;
            osccr_pkg::CFG_ADDR:         prdata_d[4:0] = {cfg_fosc,
                                                          cfg_instr_clock_out_en,
                                                          cfg_pll_force};
            osccr_pkg::STATUS_ADDR:      prdata_d[6:0] = {refclk_pin_oe, xtal_mode,
                                                          osc_div_exp, osc_src};
            default:                     prdata_d = 32'h0000_0000;
        endcase
    end

    // read data captured in the setup phase, held through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;

    // ************************************************************
    // oscillator selection
    // ************************************************************
    osccr_osc_sel u_osc_sel (
        .sw_pll_enable    (osc_ctrl_q[osccr_pkg::OSC_PLL_BIT]),
        .int_osc_freq_sel (osc_ctrl_q[osccr_pkg::OSC_FREQ_LSB +: 4]),
        .sys_clk_select   (osc_ctrl_q[osccr_pkg::OSC_SCS_LSB +: 2]),
        .cfg_pll_force    (cfg_pll_force),
        .pll_on           (pll_on),
        .osc_src          (src),
        .osc_div_exp      (osc_div_exp)
    );
    assign osc_src = src;

    // ************************************************************
    // reference clock generator
    // ************************************************************
    osccr_refclk_gen #(
        .DIV_W (3)
    ) u_refclk (
        .pclk     (pclk),
        .presetn  (presetn),
        .enable   (ref_ctrl_q[osccr_pkg::REF_EN_BIT]),
        .div_sel  (ref_ctrl_q[osccr_pkg::REF_DIV_LSB +: 3]),
        .duty_sel (ref_ctrl_q[osccr_pkg::REF_DUTY_LSB +: 2]),
        .ref_clk  (ref_clk)
    );

    assign modulator_clk = ref_clk;

    // ************************************************************
    // instruction clock: system clock divided by four
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_cnt_q <= 2'h0;
            instr_div_q <= 1'b0;
        end else begin
            instr_cnt_q <= instr_cnt_q + 2'h1;
            if (instr_cnt_q[0]) begin
                instr_div_q <= ~instr_div_q;
            end
        end
    end

    // ************************************************************
    // pin arbitration
    // ************************************************************
    assign xtal_mode = (cfg_fosc == osccr_pkg::FOSC_LP) ||
                       (cfg_fosc == osccr_pkg::FOSC_XT) ||
                       (cfg_fosc == osccr_pkg::FOSC_HS);
    assign osc_second_pin_is_input = xtal_mode;

    always_comb begin
        refclk_pin_o  = 1'b0;
        refclk_pin_oe = 1'b0;
        if (xtal_mode) begin
            refclk_pin_oe = 1'b0;
        end else if (cfg_instr_clock_out_en) begin
            refclk_pin_o  = instr_div_q;
            refclk_pin_oe = 1'b1;
        end else if (ref_ctrl_q[osccr_pkg::REF_OE_BIT]) begin
            refclk_pin_o  = ref_clk;
            refclk_pin_oe = 1'b1;
        end
    end

    assign refclk_slew_limit_o = ref_ctrl_q[osccr_pkg::REF_SLEW_BIT];

endmodule

// ---- osccr_assertions.sv ----
/* checker for osccr_top: shadows both control registers from apb writes.
   assumes one clock, zero wait states and steady configuration inputs */
`timescale 1ns/10ps
module osccr_chk (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    // configuration and outputs
    input wire logic        cfg_pll_force,
    input wire logic        cfg_instr_clock_out_en,
    input wire logic [2:0]  cfg_fosc,
    input wire logic        pll_on,
    input wire logic [1:0]  osc_src,
    input wire logic        refclk_pin_oe,
    input wire logic        refclk_slew_limit_o,
    input wire logic        osc_second_pin_is_input,
    input wire logic        modulator_clk
);
    logic [7:0] osc_q;
    logic [7:0] ref_q;
    logic [4:0] run_q;
    logic       wr;
    logic       xtal;
    assign wr   = psel && penable && pwrite && pready;
    assign xtal = cfg_fosc <= osccr_pkg::FOSC_HS;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_q <= osccr_pkg::OSC_CTRL_RESET;
            ref_q <= osccr_pkg::REF_CTRL_RESET;
        end else if (wr && paddr == osccr_pkg::OSC_CTRL_ADDR) begin
            osc_q <= pwdata[7:0] & osccr_pkg::OSC_CTRL_MASK;
        end else if (wr && paddr == osccr_pkg::REFCLK_CTRL_ADDR) begin
            ref_q <= pwdata[7:0];
        end
    end
    // cycles spent enabled at divide by two with half duty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 5'h00;
        end else if (ref_q[7] && ref_q[4:0] == 5'h11 && !wr) begin
            run_q <= run_q + {4'h0, run_q != 5'h1F};
        end else begin
            run_q <= 5'h00;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    pll_follow_a: assert property (pll_on == (cfg_pll_force || osc_q[7]))
        else $error("pll state wrong");
    hf_band_a: assert property (osc_q[1] && osc_q[6] |-> osc_src == 2'h1)
        else $error("hf source not chosen");
    lf_band_a: assert property (osc_q[1] && osc_q[6:4] == 3'h0 |-> osc_src == 2'h3)
        else $error("lf source not chosen");
    cfg_src_a: assert property (osc_q[1:0] == 2'h0 |-> osc_src == 2'h0)
        else $error("config source not chosen");
    bit_two_a: assert property (
        psel && penable && !pwrite && paddr == osccr_pkg::OSC_CTRL_ADDR |-> !prdata[2])
        else $error("bit two reads one");
    slew_pad_a: assert property (refclk_slew_limit_o == ref_q[5])
        else $error("slew control wrong");
    pin_drive_a: assert property (
        refclk_pin_oe |-> !xtal && (ref_q[6] || cfg_instr_clock_out_en))
        else $error("pin driven without cause");
    instr_clock_pin_output_prio_a: assert property (cfg_instr_clock_out_en && !xtal |-> refclk_pin_oe)
        else $error("clock out not driven");
    xtal_pin_a: assert property (osc_second_pin_is_input == xtal)
        else $error("oscillator pin mode wrong");
    idle_low_a: assert property (!ref_q[7] [*3] |-> !modulator_clk)
        else $error("clock runs while disabled");
    div_two_a: assert property (
        run_q > 5'h0C |-> modulator_clk != $past(modulator_clk))
        else $error("divide by two not toggling");
    run_c: cover property (run_q == 5'h1F);
    conflict_c: cover property (xtal && run_q > 5'h0C);
    instr_clock_pin_output_c: cover property (cfg_instr_clock_out_en && refclk_pin_oe);
endmodule
bind osccr_top osccr_chk i_osccr_chk (.*);

// ---- osccr_pin_load.sv ----
/* pin load model: an external device fed from the reference clock pin.
   assumes pclk sampling; gives last full period and high time in cycles */
`timescale 1ns/10ps
module osccr_pin_load (
    // clock
    input wire logic   pclk,
    // pad
    input wire logic   pin_o,
    input wire logic   pin_oe,
    // measurement
    output logic [7:0] per_q,
    output logic [7:0] hi_q
);
    logic       pad;
    logic       last_q;
    logic [7:0] cnt_q;
    logic [7:0] hcnt_q;
    // an undriven pad flips each cycle so it never passes for a level
    assign pad = pin_oe ? pin_o : !last_q;
    always_ff @(posedge pclk) begin
        last_q <= pad;
        if (pad && !last_q) begin
            per_q  <= cnt_q;
            hi_q   <= hcnt_q;
            cnt_q  <= 8'h01;
            hcnt_q <= 8'h01;
        end else begin
            cnt_q  <= cnt_q + 8'h01;
            hcnt_q <= hcnt_q + {7'h0, pad};
        end
    end
endmodule

// ---- tb.sv ----
/* testbench for osccr_top: apb master, register table, clock tables.
   assumes the pin load model and the bound checker */
`timescale 1ns/10ps
module tb;
    typedef struct packed {logic [7:0] w; logic [1:0] src; logic [2:0] dexp;
                           logic pll;} osccr_orow_t;
    typedef struct packed {logic [7:0] w; logic [7:0] per; logic [7:0] hi;} osccr_rrow_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, m0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        cfg_pll_force, cfg_instr_clock_out_en, pll_on, modulator_clk;
    logic [2:0]  cfg_fosc, osc_div_exp;
    logic [1:0]  osc_src;
    logic        refclk_pin_o, refclk_pin_oe, refclk_slew_limit_o, osc_second_pin_is_input;
    logic [7:0]  per_q, hi_q;
    int          error_cnt, n_checks, n;
    osccr_orow_t orows [8] = '{'{8'h7A, 2'h1, 3'h0, 1'b0}, '{8'hF6, 2'h1, 3'h1, 1'b1},
                             '{8'h42, 2'h1, 3'h7, 1'b0}, '{8'h3B, 2'h2, 3'h0, 1'b0},
                             '{8'h13, 2'h2, 3'h4, 1'b0}, '{8'h0B, 2'h3, 3'h0, 1'b0},
                             '{8'h02, 2'h3, 3'h0, 1'b0}, '{8'h78, 2'h0, 3'h0, 1'b0}};
    osccr_rrow_t rrows [8] = '{'{8'hCA, 8'h04, 8'h01}, '{8'hDA, 8'h04, 8'h03},
                             '{8'hD3, 8'h08, 8'h04}, '{8'hCB, 8'h08, 8'h02},
                             '{8'hDC, 8'h10, 8'h0C}, '{8'hCD, 8'h20, 8'h08},
                             '{8'hF6, 8'h40, 8'h20}, '{8'hD7, 8'h80, 8'h40}};
    // control word, then high samples counted on both edges over eight cycles
    logic [15:0] erows [3] = '{16'hD90C, 16'hC904, 16'hC808};
    osccr_top i_osccr_top (.*);
    osccr_pin_load i_osccr_pin_load (.pclk(pclk), .pin_o(refclk_pin_o), .pin_oe(refclk_pin_oe),
                                     .per_q(per_q), .hi_q(hi_q));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            error_cnt++;
            print_verdict();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cfg_ref(input logic [7:0] w);
        apb(1'b1, osccr_pkg::REFCLK_CTRL_ADDR, w & 8'h7F);
        apb(1'b1, osccr_pkg::REFCLK_CTRL_ADDR, w);
    endtask
    task automatic do_reset(input logic pf, input logic co, input logic [2:0] fo);
        presetn <= 1'b0;
        cfg_pll_force <= pf;
        cfg_instr_clock_out_en <= co;
        cfg_fosc <= fo;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        error_cnt = 0;
        n_checks = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        do_reset(1'b0, 1'b0, 3'h4);
        apb(1'b0, osccr_pkg::OSC_CTRL_ADDR, 8'h00);
        chk(rd, 32'h38);
        foreach (orows[i]) begin
            apb(1'b1, osccr_pkg::OSC_CTRL_ADDR, orows[i].w);
            apb(1'b0, osccr_pkg::OSC_CTRL_ADDR, 8'h00);
            chk(rd, {24'h0, orows[i].w & osccr_pkg::OSC_CTRL_MASK});
            chk({30'h0, osc_src}, {30'h0, orows[i].src});
            chk({29'h0, osc_div_exp}, {29'h0, orows[i].dexp});
            chk({31'h0, pll_on}, {31'h0, orows[i].pll});
        end
        foreach (rrows[i]) begin
            cfg_ref(rrows[i].w);
            apb(1'b0, osccr_pkg::REFCLK_CTRL_ADDR, 8'h00);
            chk(rd, {24'h0, rrows[i].w});
            repeat (300) @(posedge pclk);
            #1;
            chk({per_q, hi_q}, {rrows[i].per, rrows[i].hi});
            chk({31'h0, refclk_slew_limit_o}, {31'h0, rrows[i].w[5]});
        end
        cfg_ref(8'hC0);
        repeat (8) begin
            @(posedge pclk);
            #1;
            chk({31'h0, refclk_pin_o}, 32'h0);
        end
        foreach (erows[j]) begin
            cfg_ref(erows[j][15:8]);
            repeat (4) @(posedge pclk);
            n = 0;
            repeat (8) begin
                @(posedge pclk);
                #1;
                n += (refclk_pin_o === 1'b1);
                @(negedge pclk);
                #1;
                n += (refclk_pin_o === 1'b1);
            end
            chk(n, {24'h0, erows[j][7:0]});
        end
        apb(1'b0, 12'h010, 8'h00);
        chk({err, rd[30:0]}, 32'h80000000);
        do_reset(1'b1, 1'b0, 3'h4);
        apb(1'b0, osccr_pkg::REFCLK_CTRL_ADDR, 8'h00);
        chk({rd[31:1], modulator_clk}, 32'h0);
        apb(1'b1, osccr_pkg::OSC_CTRL_ADDR, 8'h00);
        chk({31'h0, pll_on}, 32'h1);
        do_reset(1'b0, 1'b1, 3'h4);
        repeat (20) @(posedge pclk);
        #1;
        chk({23'h0, refclk_pin_oe, per_q}, {23'h0, 1'b1, 8'h04});
        do_reset(1'b0, 1'b1, 3'h1);
        cfg_ref(8'hD1);
        repeat (20) @(posedge pclk);
        #1;
        chk({30'h0, osc_second_pin_is_input, refclk_pin_oe}, 32'h2);
        n = 0;
        repeat (8) begin
            m0 = modulator_clk;
            @(posedge pclk);
            #1;
            n += (modulator_clk !== m0);
        end
        chk(n, 8);
        print_verdict();
    end
endmodule
